// file: common/blob_pkg.sv
// Constants, register map and field layout of the logic output bank
package blob_pkg;
    // Bank shape
    localparam int NOUT = 16;
    localparam int NGRP = 8;
    localparam int NGPI = 16;
    localparam int NRAIL = 4;
    localparam int NRTYPE = 16;
    localparam int NSTK = NRAIL * NRTYPE + 2;

    // Evaluation pacing: one scan of all outputs per tick
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] TICK_LAST = 9'(TICK_CYCLES - 1);

    // Register map (byte addresses, 12-bit window)
    localparam logic [11:0] CFG_BASE = 12'h000;
    localparam logic [11:0] OUT_STATE = 12'h100;
    localparam logic [11:0] STICKY_CLEAR = 12'h104;
    localparam logic [11:0] STICKY_RAIL01 = 12'h108;
    localparam logic [11:0] STICKY_RAIL23 = 12'h10C;
    localparam logic [11:0] STICKY_SYS = 12'h110;
    localparam logic [11:0] CLEAR_SRC = 12'h114;

    // Per-output config words: index = {output, word}
    localparam logic [1:0] W_PATH1 = 2'h0;
    localparam logic [1:0] W_PATH2 = 2'h1;
    localparam logic [1:0] W_CTRL = 2'h2;

    // Control word fields
    localparam int C_GATE = 0;
    localparam int C_SM = 2;
    localparam int C_POL = 3;
    localparam int C_OD = 4;
    localparam int C_DLY = 5;
    localparam int C_T1 = 14;
    localparam int C_T2 = 23;
    // Rail term fields, relative to term base
    localparam int T_FLAG = 0;
    localparam int T_STK = 5;
    localparam int T_RAIL = 6;
    localparam int T_EN = 8;

    // Rail flag codes
    localparam logic [4:0] F_GOOD = 5'h00;
    localparam logic [4:0] F_WDOG = 5'h10;
    localparam logic [4:0] F_UPSET = 5'h11;

    // Reset values: active high, push-pull, no logic
    localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
    localparam logic [31:0] PATH_RESET = 32'h0000_0000;
    localparam logic [4:0] CLRSRC_RESET = 5'h00;

    typedef enum logic [1:0] {GATE_AND, GATE_OR, GATE_NOR, GATE_AND2} blob_gate_e;
    typedef enum logic [2:0] {
        SC_IDLE, SC_RD0, SC_RD1, SC_RD2, SC_EVAL, SC_COMMIT
    } blob_scan_e;
endpackage : blob_pkg

// file: design/blob_cfg_mem.sv
// Per-output configuration store, two registered read ports
`timescale 1ns/100ps
module blob_cfg_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write port
    input wire logic wrEn,
    input wire logic [5:0] wrAddr,
    input wire logic [31:0] wrData,
    // Bus read port
    input wire logic [5:0] rdAddrA,
    output logic [31:0] rdDataA,
    // Scanner read port
    input wire logic [5:0] rdAddrB,
    output logic [31:0] rdDataB
);
    logic [31:0] mem_q [64];
    logic [31:0] mem_d [64];
    logic [31:0] rdA_d;
    logic [31:0] rdB_d;
    logic [31:0] rdA_q;
    logic [31:0] rdB_q;

    always_comb begin
        for (int i = 0; i < 64; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wrEn) begin
            mem_d[wrAddr] = wrData;
        end
        rdA_d = mem_q[rdAddrA];
        rdB_d = mem_q[rdAddrB];
    end

    // Reset to known config so outputs start inactive
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= (2'(i) == blob_pkg::W_CTRL) ?
                    blob_pkg::CTRL_RESET : blob_pkg::PATH_RESET;
            end
            rdA_q <= 32'h0000_0000;
            rdB_q <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= mem_d[i];
            end
            rdA_q <= rdA_d;
            rdB_q <= rdB_d;
        end
    end

    assign rdDataA = rdA_q;
    assign rdDataB = rdB_q;
endmodule : blob_cfg_mem

// file: design/blob_logic_out_bank.sv
// Sixteen Boolean-logic driven output pins with APB configuration
`timescale 1ns/100ps
module blob_logic_out_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // General input pins, asynchronous
    input wire logic [15:0] generalInput,
    // Sequencer core status, same clock
    input wire logic [63:0] railStatus,
    input wire logic [3:0] railHasMonitor,
    input wire logic watchdogTimeout,
    input wire logic upsetDetectedFlag,
    // Logic output pins
    output logic [15:0] logicOutputPinOut,
    output logic [15:0] logicOutputPinOe
);
    localparam int N = blob_pkg::NOUT;

    logic [15:0] gpiMeta_q, gpiSync_q;
    logic [65:0] sticky_q, sticky_d;
    logic [4:0] clrSrc_q, clrSrc_d;
    logic gpiClrPrev_q, gpiClrPrev_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [15:0] pinOut_q, pinOut_d, pinOe_q, pinOe_d;

    blob_pkg::blob_scan_e scan_q, scan_d;
    logic [8:0] tick_q, tick_d;
    logic [3:0] idx_q, idx_d;
    logic [31:0] p1_q, p1_d, p2_q, p2_d;
    logic [65:0] snapRail_q, snapRail_d, prevRail_q, prevRail_d;
    logic [31:0] snapIn_q, snapIn_d, prevIn_q, prevIn_d;
    logic first_q, first_d;
    logic [15:0] res_q, res_d, shadow_q, shadow_d;
    logic [15:0] path2_q, path2_d, pol_q, pol_d, od_q, od_d;
    logic [7:0] dly_q [N];
    logic [7:0] dly_d [N];

    logic [65:0] liveRail;
    logic busWrite, cfgHit, memWe;
    logic [5:0] scanAddr;
    logic [31:0] rdBus, rdScan;

    // Live rail flag vector; good masked by monitor presence
    always_comb begin
        liveRail = {upsetDetectedFlag, watchdogTimeout, railStatus};
        for (int r = 0; r < blob_pkg::NRAIL; r++) begin
            liveRail[r * blob_pkg::NRTYPE + int'(blob_pkg::F_GOOD)] =
                railStatus[r * blob_pkg::NRTYPE + int'(blob_pkg::F_GOOD)]
                & railHasMonitor[r];
        end
    end

    // Pick one rail term: live or sticky, by rail and flag code
    function automatic logic railTerm(input logic [8:0] t,
                                      input logic [65:0] live,
                                      input logic [65:0] stk);
        logic [6:0] pos;
        logic [65:0] src;
        src = t[blob_pkg::T_STK] ? stk : live;
        if (t[blob_pkg::T_FLAG +: 5] == blob_pkg::F_WDOG) begin
            pos = 7'h40;
        end else if (t[blob_pkg::T_FLAG +: 5] == blob_pkg::F_UPSET) begin
            pos = 7'h41;
        end else begin
            pos = {1'b0, t[blob_pkg::T_RAIL +: 2], t[blob_pkg::T_FLAG +: 4]};
        end
        return src[pos];
    endfunction : railTerm

    // AND of selected terms; an empty path is false
    function automatic logic pathEval(input logic [31:0] mask,
                                      input logic [31:0] ins,
                                      input logic [8:0] t,
                                      input logic [65:0] live,
                                      input logic [65:0] stk);
        logic any, ok;
        any = (|mask) | t[blob_pkg::T_EN];
        ok = &(ins | ~mask);
        if (t[blob_pkg::T_EN]) begin
            ok = ok & railTerm(t, live, stk);
        end
        return any & ok;
    endfunction : pathEval

    // Bus side: registered answer one cycle into the access phase
    always_comb begin
        cfgHit = (paddr[11:8] == 4'h0) && (paddr[3:2] != 2'h3);
        pready_d = psel & penable & ~pready_q;
        busWrite = psel & penable & pready_q & pwrite;
        memWe = busWrite & cfgHit;
        prdata_d = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (cfgHit) begin
            prdata_d = rdBus;
        end else if (paddr == blob_pkg::OUT_STATE) begin
            prdata_d = {path2_q, res_q};
        end else if (paddr == blob_pkg::STICKY_CLEAR) begin
            prdata_d = 32'h0000_0000;
        end else if (paddr == blob_pkg::STICKY_RAIL01) begin
            prdata_d = sticky_q[31:0];
        end else if (paddr == blob_pkg::STICKY_RAIL23) begin
            prdata_d = sticky_q[63:32];
        end else if (paddr == blob_pkg::STICKY_SYS) begin
            prdata_d = {30'h0, sticky_q[65:64]};
        end else if (paddr == blob_pkg::CLEAR_SRC) begin
            prdata_d = {27'h0, clrSrc_q};
        end else begin
            pslverr_d = 1'b1;
        end
        if (!pready_d) begin
            prdata_d = prdata_q;
            pslverr_d = 1'b0;
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_comb begin
        logic cmdClr, gpiLvl, gpiClr;
        cmdClr = busWrite && (paddr == blob_pkg::STICKY_CLEAR) && pwdata[0];
        gpiLvl = gpiSync_q[clrSrc_q[3:0]];
        gpiClr = clrSrc_q[4] & gpiLvl & ~gpiClrPrev_q;
        gpiClrPrev_d = gpiLvl;
        clrSrc_d = clrSrc_q;
        if (busWrite && (paddr == blob_pkg::CLEAR_SRC)) begin
            clrSrc_d = pwdata[4:0];
        end
        sticky_d = (sticky_q & ~{66{cmdClr | gpiClr}}) | liveRail;
    end

    // Scanner: reads each output's config, evaluates, commits on a tick
    always_comb begin
        logic [31:0] ctrl;
        logic r1, r2, tgt, chg;
        ctrl = rdScan;
        r1 = 1'b0;
        r2 = 1'b0;
        tgt = 1'b0;
        chg = 1'b0;
        scan_d = scan_q;
        tick_d = (tick_q == blob_pkg::TICK_LAST) ? 9'h000 : tick_q + 9'h001;
        idx_d = idx_q;
        p1_d = p1_q;
        p2_d = p2_q;
        snapIn_d = snapIn_q;
        snapRail_d = snapRail_q;
        prevIn_d = prevIn_q;
        prevRail_d = prevRail_q;
        first_d = first_q;
        res_d = res_q;
        shadow_d = shadow_q;
        path2_d = path2_q;
        pol_d = pol_q;
        od_d = od_q;
        pinOut_d = pinOut_q;
        pinOe_d = pinOe_q;
        scanAddr = {idx_q, blob_pkg::W_PATH1};
        dly_d = dly_q;
        case (scan_q)
            blob_pkg::SC_IDLE: begin
                // One scan per tick keeps latency between about 0.2 and 1.2 us
                if (tick_q == blob_pkg::TICK_LAST) begin
                    snapIn_d = {res_q, gpiSync_q};
                    snapRail_d = liveRail;
                    idx_d = 4'h0;
                    scan_d = blob_pkg::SC_RD0;
                end
            end
            blob_pkg::SC_RD0: begin
                scanAddr = {idx_q, blob_pkg::W_PATH2};
                p1_d = rdScan;
                scan_d = blob_pkg::SC_RD1;
            end
            blob_pkg::SC_RD1: begin
                scanAddr = {idx_q, blob_pkg::W_CTRL};
                p2_d = rdScan;
                scan_d = blob_pkg::SC_EVAL;
            end
            blob_pkg::SC_EVAL: begin
                r1 = pathEval(p1_q, snapIn_q, ctrl[blob_pkg::C_T1 +: 9],
                              snapRail_q, sticky_q);
                r2 = pathEval(p2_q, snapIn_q, ctrl[blob_pkg::C_T2 +: 9],
                              snapRail_q, sticky_q);
                chg = first_q | (|((snapIn_q ^ prevIn_q) & (p1_q | p2_q)))
                      | (snapRail_q != prevRail_q);
                if (ctrl[blob_pkg::C_SM]) begin
                    tgt = path2_q[idx_q] ? r2 : r1;
                    if (chg && !path2_q[idx_q] && !r1) begin
                        path2_d[idx_q] = 1'b1;
                    end else if (chg && path2_q[idx_q] && r2) begin
                        path2_d[idx_q] = 1'b0;
                    end
                end else begin
                    path2_d[idx_q] = 1'b0;
                    case (blob_pkg::blob_gate_e'(ctrl[blob_pkg::C_GATE +: 2]))
                        blob_pkg::GATE_OR: tgt = r1 | r2;
                        blob_pkg::GATE_NOR: tgt = ~(r1 | r2);
                        default: tgt = r1 & r2;
                    endcase
                end
                // Delay counts ticks; a change must persist to pass
                if (tgt == res_q[idx_q]) begin
                    dly_d[idx_q] = 8'h00;
                    shadow_d[idx_q] = res_q[idx_q];
                end else if (dly_q[idx_q] >= ctrl[blob_pkg::C_DLY +: 8]) begin
                    dly_d[idx_q] = 8'h00;
                    shadow_d[idx_q] = tgt;
                end else begin
                    dly_d[idx_q] = dly_q[idx_q] + 8'h01;
                    shadow_d[idx_q] = res_q[idx_q];
                end
                pol_d[idx_q] = ctrl[blob_pkg::C_POL];
                od_d[idx_q] = ctrl[blob_pkg::C_OD];
                idx_d = idx_q + 4'h1;
                scanAddr = {idx_d, blob_pkg::W_PATH1}; // Next path one
                scan_d = (idx_q == 4'hF) ? blob_pkg::SC_COMMIT :
                                           blob_pkg::SC_RD0;
            end
            blob_pkg::SC_COMMIT: begin
                // Both groups of eight switch on this one edge
                res_d = shadow_q;
                for (int i = 0; i < N; i++) begin
                    tgt = pol_q[i] ? shadow_q[i] : ~shadow_q[i];
                    pinOut_d[i] = od_q[i] ? 1'b0 : tgt;
                    pinOe_d[i] = od_q[i] ? ~tgt : 1'b1;
                end
                prevIn_d = snapIn_q;
                prevRail_d = snapRail_q;
                first_d = 1'b0;
                scan_d = blob_pkg::SC_IDLE;
            end
            default: scan_d = blob_pkg::SC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gpiMeta_q <= 16'h0000;
            gpiSync_q <= 16'h0000;
            sticky_q <= 66'h0;
            clrSrc_q <= blob_pkg::CLRSRC_RESET;
            gpiClrPrev_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            scan_q <= blob_pkg::SC_IDLE;
            tick_q <= 9'h000;
            idx_q <= 4'h0;
            p1_q <= 32'h0000_0000;
            p2_q <= 32'h0000_0000;
            snapIn_q <= 32'h0000_0000;
            snapRail_q <= 66'h0;
            prevIn_q <= 32'h0000_0000;
            prevRail_q <= 66'h0;
            first_q <= 1'b1;
            res_q <= 16'h0000;
            shadow_q <= 16'h0000;
            path2_q <= 16'h0000;
            pol_q <= 16'hFFFF;
            od_q <= 16'h0000;
            pinOut_q <= 16'h0000;
            pinOe_q <= 16'hFFFF;
            dly_q <= '{default: 8'h00};
        end else begin
            gpiMeta_q <= generalInput;
            gpiSync_q <= gpiMeta_q;
            sticky_q <= sticky_d;
            clrSrc_q <= clrSrc_d;
            gpiClrPrev_q <= gpiClrPrev_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            scan_q <= scan_d;
            tick_q <= tick_d;
            idx_q <= idx_d;
            p1_q <= p1_d;
            p2_q <= p2_d;
            snapIn_q <= snapIn_d;
            snapRail_q <= snapRail_d;
            prevIn_q <= prevIn_d;
            prevRail_q <= prevRail_d;
            first_q <= first_d;
            res_q <= res_d;
            shadow_q <= shadow_d;
            path2_q <= path2_d;
            pol_q <= pol_d;
            od_q <= od_d;
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
            dly_q <= dly_d;
        end
    end

    blob_cfg_mem u_cfg (
        .clk(clk), .rst(rst),
        .wrEn(memWe), .wrAddr(paddr[7:2]), .wrData(pwdata),
        .rdAddrA(paddr[7:2]), .rdDataA(rdBus),
        .rdAddrB(scanAddr), .rdDataB(rdScan)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign logicOutputPinOut = pinOut_q;
    assign logicOutputPinOe = pinOe_q;
endmodule : blob_logic_out_bank

// file: verification/blob_board_load.sv
// Board loads on the logic output pins
`timescale 1ns/100ps
module blob_board_load (
    // Drive from the bank
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOe,
    // Level seen on the board
    output logic [15:0] pinLevel
);
    // Every pin has a pull-up, so a released pin reads high
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pinLevel[i] = pinOe[i] ? pinOut[i] : 1'b1;
        end
    end
endmodule : blob_board_load

// file: verification/blob_logic_out_bank_monitor.sv
// Bus and pin checker for the logic output bank
`timescale 1ns/100ps
module blob_logic_out_bank_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Logic output pins
    input wire logic [15:0] logicOutputPinOut,
    input wire logic [15:0] logicOutputPinOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wait_state;
        !pready ##1 pready;
    endsequence

    sequence s_pins_hold;
        $stable({logicOutputPinOut, logicOutputPinOe})[*8];
    endsequence

    a_reset_pins: assert property (disable iff (1'b0)
        rst |=> logicOutputPinOut == 16'h0000 && logicOutputPinOe == 16'hFFFF)
        else $error("pins not inactive after reset");
    a_ready_wait: assert property (
        psel && $rose(penable) |-> s_wait_state)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (
        pready && paddr < 12'h100 && paddr[3:2] == 2'h3 |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (
        pready && paddr < 12'h100 && paddr[3:2] != 2'h3 |-> !pslverr)
        else $error("mapped access refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_hold: assert property ($changed(prdata) |-> pready)
        else $error("read data moved outside completion");
    a_od_release: assert property (
        (logicOutputPinOut & ~logicOutputPinOe) == 16'h0000)
        else $error("released pin with high drive level");
    a_group_commit: assert property (
        $changed({logicOutputPinOut, logicOutputPinOe}) |=> s_pins_hold)
        else $error("pins changed outside a single commit");
endmodule : blob_logic_out_bank_monitor

bind blob_logic_out_bank blob_logic_out_bank_monitor i_mon (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .logicOutputPinOut(logicOutputPinOut),
    .logicOutputPinOe(logicOutputPinOe)
);

// file: verification/blob_logic_out_bank_tb.sv
// Directed testbench for the logic output bank
`timescale 1ns/100ps
module blob_logic_out_bank_tb;
    // Output 8 runs as state machine; 4, 5 and 7 use rail terms
    localparam logic [43:0] CFG_TAB [15] = '{
        44'h000_00000001, 44'h008_00000009, 44'h018_0000000A,
        44'h020_00000001, 44'h028_00000019, 44'h030_00010000,
        44'h038_00000009, 44'h048_00400009, 44'h058_0048C009,
        44'h060_00000001, 44'h068_00000001, 44'h080_00000002,
        44'h084_00000004, 44'h088_0000000C, 44'h078_00440009};
    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] gpIn;
    logic [63:0] railStatus;
    logic [3:0] railHasMonitor;
    logic [15:0] pinOut;
    logic [15:0] pinOe;
    logic [15:0] pinLevel;
    logic [31:0] rdata;
    logic err;
    logic wdog;
    logic upset;
    int failures;
    int testsRun;
    int n;

    blob_logic_out_bank i_dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .generalInput(gpIn), .railStatus(railStatus),
        .railHasMonitor(railHasMonitor), .watchdogTimeout(wdog),
        .upsetDetectedFlag(upset), .logicOutputPinOut(pinOut),
        .logicOutputPinOe(pinOe));
    blob_board_load i_load (.pinOut(pinOut), .pinOe(pinOe),
        .pinLevel(pinLevel));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // Ready is looked at on the rising edge that completes the transfer
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            failures++;
            print_verdict();
        end
        rdata = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Three scan ticks cover sync, snapshot, scan and commit
    task automatic settle;
        repeat (3 * blob_pkg::TICK_CYCLES) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic pins(input logic [15:0] o, input logic [15:0] e);
        check({16'h0000, pinOut}, {16'h0000, o});
        check({16'h0000, pinOe}, {16'h0000, e});
        check({16'h0000, pinLevel}, {16'h0000, o | ~e});
    endtask : pins

    task automatic gpSet(input logic [15:0] v);
        @(posedge clk);
        gpIn <= v;
        settle();
    endtask : gpSet

    initial begin
        failures = 0;
        testsRun = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        gpIn = 16'h0000;
        railStatus = 64'h0000_0000_0000_0001;
        railHasMonitor = 4'h0;
        wdog = 1'b0;
        upset = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        pins(16'h0000, 16'hFFFF);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(rdata, blob_pkg::CTRL_RESET);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        for (int i = 0; i < 15; i++) begin
            apb(1'b1, CFG_TAB[i][43:32], CFG_TAB[i][31:0]);
        end
        apb(1'b0, 12'h058, 32'h0000_0000);
        check(rdata, 32'h0048_C009);
        settle();
        pins(16'h0042, 16'hFFFF);
        gpSet(16'h0001);
        pins(16'h000B, 16'hFFFB);
        apb(1'b0, blob_pkg::OUT_STATE, 32'h0000_0000);
        check({16'h0000, rdata[15:0]}, 32'h0000_004F);
        // Short fault pulse must be held by the sticky copy
        @(posedge clk);
        railStatus <= 64'h0000_0000_0000_0009;
        repeat (10) @(posedge clk);
        railStatus <= 64'h0000_0000_0000_0001;
        settle();
        pins(16'h002B, 16'hFFFB);
        apb(1'b0, blob_pkg::STICKY_RAIL01, 32'h0000_0000);
        check(rdata, 32'h0000_0008);
        apb(1'b1, blob_pkg::STICKY_CLEAR, 32'h0000_0001);
        settle();
        pins(16'h000B, 16'hFFFB);
        apb(1'b0, blob_pkg::STICKY_RAIL01, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        @(posedge clk);
        railHasMonitor <= 4'h1;
        settle();
        pins(16'h001B, 16'hFFFB);
        // System flags: live copy drives output 7, sticky copy is read
        @(posedge clk);
        wdog <= 1'b1;
        upset <= 1'b1;
        settle();
        pins(16'h009B, 16'hFFFB);
        apb(1'b0, blob_pkg::STICKY_SYS, 32'h0000_0000);
        check(rdata, 32'h0000_0003);
        @(posedge clk);
        wdog <= 1'b0;
        upset <= 1'b0;
        apb(1'b1, blob_pkg::CLEAR_SRC, 32'h0000_001F);
        apb(1'b0, blob_pkg::CLEAR_SRC, 32'h0000_0000);
        check(rdata, 32'h0000_001F);
        gpSet(16'h8001);
        apb(1'b0, blob_pkg::STICKY_SYS, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        apb(1'b1, 12'h118, 32'h0000_0001);
        check({31'h0, err}, 32'h0000_0001);
        gpSet(16'h0003);
        pins(16'h001B, 16'hFFFB);
        apb(1'b0, blob_pkg::OUT_STATE, 32'h0000_0000);
        check({31'h0, rdata[24]}, 32'h0000_0001);
        @(posedge clk);
        gpIn <= 16'h0007;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pinOut[8] !== 1'b1 && n < 750);
        check({31'h0, n >= 750}, 32'h0000_0000);
        settle();
        pins(16'h011B, 16'hFFFB);
        // Path two true but unchanged inputs: no further step
        gpSet(16'h0005);
        pins(16'h011B, 16'hFFFB);
        apb(1'b0, blob_pkg::OUT_STATE, 32'h0000_0000);
        check({31'h0, rdata[24]}, 32'h0000_0001);
        // Two-tick delay on output 0: a fall must persist three scans
        apb(1'b1, 12'h008, 32'h0000_0049);
        @(posedge clk);
        gpIn <= 16'h0004;
        repeat (400) @(posedge clk);
        @(negedge clk);
        check({31'h0, pinOut[0]}, 32'h0000_0001);
        settle();
        pins(16'h0152, 16'hFFFF);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        pins(16'h0000, 16'hFFFF);
        print_verdict();
    end
endmodule : blob_logic_out_bank_tb
